// *** design/sar_adc_pkg.sv ***
// shared constants for the converter readout link
// How it works
// - device yields 16-bit results, up to 500 kHz
// - full result on 16 lines, bit 15 MSB
// - narrow option: two reads per result
// - half-select low gives MSBs, high LSBs
// - busy high exactly while converting
// - conversion steps follow external conversion clock
// - host pulses read strobe per word or half
package sar_adc_pkg;
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned HALF_W = 8;
  localparam int unsigned SAMPLE_RATE_KHZ = 500;
  localparam int unsigned CLK_MHZ = 100;
  // least sample period in system cycles, rounded up
  localparam int unsigned SAMPLE_PERIOD_CYC = (CLK_MHZ * 1000 + SAMPLE_RATE_KHZ - 1) / SAMPLE_RATE_KHZ;
  // conversion clock ticks per conversion (one per bit plus sample)
  localparam int unsigned CONV_TICKS = 17;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  // host conversion clock divider, system cycles per half period
  localparam int unsigned CCLK_HALF_CYC = 5;
endpackage : sar_adc_pkg

// *** design/sar_adc_if.sv ***
// interface joining the converter and its host
`timescale 1ns/1ps
interface sar_adc_if;
  logic conversion_trigger;
  logic chip_select_n;
  logic read_strobe_n;
  logic half_select;
  logic conv_clk;
  logic busy;
  logic [15:0] result_bus; // result_bit_msb is bit 15, result_bit_lsb bit 0
  modport dev (
    input conversion_trigger, chip_select_n, read_strobe_n, half_select, conv_clk,
    output busy, result_bus
  );
  modport host (
    output conversion_trigger, chip_select_n, read_strobe_n, half_select, conv_clk,
    input busy, result_bus
  );
endinterface : sar_adc_if

// *** design/sar_adc_dev.sv ***
// converter end: sequencer, busy flag and parallel readout
`timescale 1ns/1ps
module sar_adc_dev #(
  parameter int unsigned CONV_TICKS = sar_adc_pkg::CONV_TICKS,
  parameter bit NARROW = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  sar_adc_if.dev link,
  input wire logic [15:0] sample_i,
  output logic [15:0] last_result_o
);
  // refuse tick counts that the 8-bit counter cannot serve
  if (CONV_TICKS < 2 || CONV_TICKS > 255) begin : g_bad_ticks
    $error("CONV_TICKS out of range");
  end

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } state_t;

  state_t state;
  state_t next_state;
  logic [7:0] tick_cnt;
  logic [7:0] next_tick_cnt;
  logic [15:0] held;
  logic [15:0] next_held;
  logic [15:0] result;
  logic [15:0] next_result;
  logic [7:0] dbus;
  logic [7:0] next_dbus;
  logic cclk_q;
  logic trig_q;
  logic rd_q;
  logic cclk_rise;
  logic trig_rise;
  logic rd_fall;

  assign cclk_rise = link.conv_clk & ~cclk_q;
  assign trig_rise = link.conversion_trigger & ~trig_q & ~link.chip_select_n;
  assign rd_fall = ~link.read_strobe_n & rd_q & ~link.chip_select_n;

  // edge history of the link inputs
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cclk_q <= 1'b0;
      trig_q <= 1'b0;
      rd_q <= 1'b1;
    end else begin
      cclk_q <= link.conv_clk;
      trig_q <= link.conversion_trigger;
      rd_q <= link.read_strobe_n;
    end
  end

  // conversion sequencer, stepped by conversion clock rises
  always_comb begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_held = held;
    next_result = result;
    case (state)
      ST_IDLE: begin
        if (trig_rise) begin // triggers during busy are ignored
          next_state = ST_CONV;
          next_tick_cnt = 8'h00;
          next_held = sample_i; // sample instant
        end
      end
      ST_CONV: begin
        if (cclk_rise) begin
          if (tick_cnt == 8'(CONV_TICKS - 1)) begin
            next_state = ST_IDLE;
            next_result = held;
          end else begin
            next_tick_cnt = tick_cnt + 8'h01;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // readout: strobe falling edge loads the half picked by half_select into dbus
  always_comb begin
    next_dbus = dbus;
    if (rd_fall) begin
      if (link.half_select) begin
        next_dbus = result[7:0];
      end else begin
        next_dbus = result[15:8];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      tick_cnt <= 8'h00;
      held <= sar_adc_pkg::RESULT_RESET;
      result <= sar_adc_pkg::RESULT_RESET;
      dbus <= sar_adc_pkg::RESULT_RESET[7:0];
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      held <= next_held;
      result <= next_result;
      dbus <= next_dbus;
    end
  end

  assign link.busy = (state == ST_CONV);
  // wide: whole result on all lines; narrow: strobed half on the low lines
  assign link.result_bus = NARROW ? {result[15:8], dbus} : result;
  assign last_result_o = result;
endmodule : sar_adc_dev

// *** design/sar_adc_host.sv ***
// host end: conversion clock, trigger, busy wait, readout
`timescale 1ns/1ps
module sar_adc_host #(
  parameter bit NARROW = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  sar_adc_if.host link,
  input wire logic start_i,
  output logic ready_o,
  output logic [15:0] data_o,
  output logic data_valid_o
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_TRIG = 3'b001,
    H_WAIT = 3'b010,
    H_RD = 3'b011,
    H_RDLO = 3'b100
  } hstate_t;

  hstate_t state;
  hstate_t next_state;
  logic [3:0] div;
  logic [3:0] next_div;
  logic cclk;
  logic next_cclk;
  logic [1:0] step;
  logic [1:0] next_step;
  logic [15:0] data;
  logic [15:0] next_data;
  logic dv;
  logic next_dv;

  // conversion clock divider
  always_comb begin
    next_div = div + 4'h1;
    next_cclk = cclk;
    if (div == 4'(sar_adc_pkg::CCLK_HALF_CYC - 1)) begin
      next_div = 4'h0;
      next_cclk = ~cclk;
    end
  end

  // trigger, busy wait and read sequence
  always_comb begin
    next_state = state;
    next_step = step + 2'h1;
    next_data = data;
    next_dv = 1'b0;
    case (state)
      H_IDLE: begin
        next_step = 2'h0;
        if (start_i && !link.busy) next_state = H_TRIG;
      end
      H_TRIG: if (step == 2'h1) begin
        next_state = H_WAIT;
        next_step = 2'h0;
      end
      H_WAIT: begin
        next_step = 2'h0;
        if (!link.busy && step == 2'h0 && link.conversion_trigger == 1'b0) next_state = H_RD;
      end
      H_RD: if (step == 2'h3) begin
        next_step = 2'h0;
        if (NARROW) begin
          next_data = {link.result_bus[7:0], data[7:0]};
          next_state = H_RDLO;
        end else begin
          next_data = link.result_bus;
          next_dv = 1'b1;
          next_state = H_IDLE;
        end
      end
      H_RDLO: if (step == 2'h3) begin
        next_data = {data[15:8], link.result_bus[7:0]};
        next_dv = 1'b1;
        next_state = H_IDLE;
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= 4'h0;
      cclk <= 1'b0;
      state <= H_IDLE;
      step <= 2'h0;
      data <= sar_adc_pkg::RESULT_RESET;
      dv <= 1'b0;
    end else begin
      div <= next_div;
      cclk <= next_cclk;
      state <= next_state;
      step <= next_step;
      data <= next_data;
      dv <= next_dv;
    end
  end

  assign link.conv_clk = cclk;
  assign link.chip_select_n = (state == H_IDLE);
  assign link.conversion_trigger = (state == H_TRIG);
  // strobe low in steps 1..2 of each read phase
  assign link.read_strobe_n = !(((state == H_RD) || (state == H_RDLO)) && (step == 2'h1 || step == 2'h2));
  assign link.half_select = (state == H_RDLO);
  assign ready_o = (state == H_IDLE) && !link.busy;
  assign data_o = data;
  assign data_valid_o = dv;
endmodule : sar_adc_host

// *** tb/sar_adc_link_sva.sv ***
// assertions on the converter link wires
`timescale 1ns/1ps
module sar_adc_link_sva (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic conversion_trigger,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic busy,
  input wire logic [15:0] result_bus
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // busy only follows a trigger seen while selected
  property p_cause; $rose(busy) |-> $past(conversion_trigger) && !$past(chip_select_n); endproperty
  a_cause: assert property (p_cause) else $error("busy without trigger");
  property p_hold; $rose(busy) |=> busy [*8]; endproperty
  a_hold: assert property (p_hold) else $error("busy too short");
  property p_end; $rose(busy) |-> ##[1:400] !busy; endproperty
  a_end: assert property (p_end) else $error("busy never ends");
  property p_keep; busy && $past(busy) |-> $stable(result_bus); endproperty
  a_keep: assert property (p_keep) else $error("result moved");
  property p_trig; $rose(conversion_trigger) |-> !busy && !chip_select_n; endproperty
  a_trig: assert property (p_trig) else $error("trigger while busy");
  property p_rd; !read_strobe_n |-> !busy; endproperty
  a_rd: assert property (p_rd) else $error("read while busy");
  property p_pulse; $fell(read_strobe_n) |=> !read_strobe_n ##1 read_strobe_n; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe width");
  // strobe stays high on the fall cycle and the first read step after it
  property p_idle; $fell(busy) |-> read_strobe_n [*2]; endproperty
  a_idle: assert property (p_idle) else $error("read too soon");
endmodule : sar_adc_link_sva

// *** tb/testbench.sv ***
// self-checking bench: wide and narrow host/converter pairs
`timescale 1ns/1ps
module testbench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] sample_i = 16'h0000;
  logic [1:0] start = 2'b00;
  wire [1:0] dv;
  wire [1:0] rdy;
  wire [15:0] data [2];
  wire [15:0] last [2];
  logic [15:0] vals [4] = '{16'hFFFF, 16'h0000, 16'hA55A, 16'h8001};
  int n_mismatch = 0;
  int checks_done = 0;
  sar_adc_if ifw ();
  sar_adc_if ifn ();
  // wide pair, watched by the checker
  sar_adc_dev sar_adc_dev_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(ifw), .sample_i(sample_i),
    .last_result_o(last[0]));
  sar_adc_host #(.NARROW(1'b0)) sar_adc_host_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(ifw),
    .start_i(start[0]), .ready_o(rdy[0]), .data_o(data[0]), .data_valid_o(dv[0]));
  // narrow pair, two half reads
  sar_adc_dev #(.NARROW(1'b1)) sar_adc_dev_n_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(ifn), .sample_i(sample_i),
    .last_result_o(last[1]));
  sar_adc_host #(.NARROW(1'b1)) sar_adc_host_n_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(ifn),
    .start_i(start[1]), .ready_o(rdy[1]), .data_o(data[1]), .data_valid_o(dv[1]));
  sar_adc_link_sva sar_adc_link_sva_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .conversion_trigger(ifw.conversion_trigger), .chip_select_n(ifw.chip_select_n),
    .read_strobe_n(ifw.read_strobe_n), .busy(ifw.busy), .result_bus(ifw.result_bus));
  // system clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // one conversion on pair k; sample changes mid-run
  task automatic convert(input int k, input logic [15:0] v);
    int n;
    logic saw;
    saw = 1'b0;
    @(negedge mclk_i);
    sample_i = v;
    start[k] = 1'b1;
    @(negedge mclk_i);
    start[k] = 1'b0;
    for (n = 0; n < 1000 && dv[k] !== 1'b1; n++) begin
      @(negedge mclk_i);
      if (n == 20) sample_i = ~v;
      if ((k == 0 ? ifw.busy : ifn.busy) === 1'b1) saw = 1'b1;
    end
    check({15'h0000, dv[k]}, 16'h0001);
    check({15'h0000, saw}, 16'h0001);
    check({15'h0000, rdy[k]}, 16'h0001);
    check(last[k], v);
    if (k == 0) begin
      check(data[k], v);
      check(ifw.result_bus, v);
    end else begin
      check(data[k], v);
      check({8'h00, ifn.result_bus[7:0]}, {8'h00, v[7:0]});
    end
    $display("test pair %0d value %h done", k, v);
  endtask : convert
  // reset, then every value through both pairs
  initial begin
    repeat (16) @(negedge mclk_i);
    rst_i = 1'b0;
    for (int k = 0; k < 2; k++) begin
      foreach (vals[i]) convert(k, vals[i]);
    end
    give_verdict();
  end
  // eight conversions need about 1500 cycles
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
